// file: logic/dpa_pkg.sv
// Constants, carrier types and state encoding for the debug port activation block
package dpa_pkg;

	// ----------------------------------------------------------------
	// Timing counts, in system clock cycles
	// ----------------------------------------------------------------
	localparam int unsigned SEL_LOW_MIN    = 2;
	localparam int unsigned TRIG_PULSE_CYC = 2;
	localparam int unsigned SEL_CNT_W      = 2;

	// ----------------------------------------------------------------
	// Instruction and data register layout
	// ----------------------------------------------------------------
	localparam int unsigned IR_W        = 4;
	localparam int unsigned DR_MAX      = 32;
	localparam int unsigned DBG_W       = 8;
	localparam logic [4:0]  MSB_BYPASS  = 5'h00;
	localparam logic [4:0]  MSB_IDCODE  = 5'h1f;
	localparam logic [4:0]  MSB_DBG     = 5'h07;
	localparam logic [3:0]  IR_IDCODE   = 4'h1;
	localparam logic [3:0]  IR_DBG      = 4'h8;
	localparam logic [3:0]  IR_BYPASS   = 4'hf;
	localparam logic [3:0]  IR_CAPTURE  = 4'h1;
	localparam logic [31:0] IDCODE_VAL  = 32'h0000_0a01; // Arbitrary value

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic tck;
		logic tms;
		logic tdi;
	} dpa_pins_t;

	typedef enum logic [3:0] {
		TLR, RTI,
		SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
		SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
	} dpa_tap_state_t;

endpackage : dpa_pkg

// file: logic/dpa_sync.sv
// Two-stage level synchronizer for pins entering the system clock domain
module dpa_sync #(
	parameter int unsigned W = 3
) (
	input  wire logic         sys_clk,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	logic [W-1:0] meta_q;
	logic [W-1:0] meta_d;
	logic [W-1:0] stab_q;
	logic [W-1:0] stab_d;

	// ----------------------------------------------------------------
	// No reset: the pins must be seen while reset is held
	// ----------------------------------------------------------------
	always_comb begin
		meta_d = async_in;
		stab_d = meta_q;
	end

	always_ff @(posedge sys_clk) begin
		meta_q <= meta_d;
		stab_q <= stab_d;
	end

	assign sync_out = stab_q;

endmodule : dpa_sync

// file: logic/dpa_tap.sv
// Test access port controller state machine
module dpa_tap (
	input  wire logic            sys_clk,
	input  wire logic            rst_n,
	input  wire logic            step,
	input  wire logic            tms,
	input  wire logic            hold_reset,
	output dpa_pkg::dpa_tap_state_t state
);
	import dpa_pkg::*;

	dpa_tap_state_t state_q;
	dpa_tap_state_t state_d;

	// ----------------------------------------------------------------
	// Next state, advanced once per test clock rising edge
	// ----------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		if (hold_reset) begin
			state_d = TLR;
		end else if (step) begin
			case (state_q)
				TLR:     state_d = tms ? TLR    : RTI;
				RTI:     state_d = tms ? SEL_DR : RTI;
				SEL_DR:  state_d = tms ? SEL_IR : CAP_DR;
				CAP_DR:  state_d = tms ? EX1_DR : SH_DR;
				SH_DR:   state_d = tms ? EX1_DR : SH_DR;
				EX1_DR:  state_d = tms ? UPD_DR : PAU_DR;
				PAU_DR:  state_d = tms ? EX2_DR : PAU_DR;
				EX2_DR:  state_d = tms ? UPD_DR : SH_DR;
				UPD_DR:  state_d = tms ? SEL_DR : RTI;
				SEL_IR:  state_d = tms ? TLR    : CAP_IR;
				CAP_IR:  state_d = tms ? EX1_IR : SH_IR;
				SH_IR:   state_d = tms ? EX1_IR : SH_IR;
				EX1_IR:  state_d = tms ? UPD_IR : PAU_IR;
				PAU_IR:  state_d = tms ? EX2_IR : PAU_IR;
				EX2_IR:  state_d = tms ? UPD_IR : SH_IR;
				UPD_IR:  state_d = tms ? SEL_DR : RTI;
				default: state_d = TLR;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state_q <= TLR;
		end else begin
			state_q <= state_d;
		end
	end

	assign state = state_q;

endmodule : dpa_tap

// file: logic/dpa_top.sv
// Debug port activation: mode select at reset, test access port, serial debug pin sharing
module dpa_top #(
	parameter int unsigned TRIG_CYC = dpa_pkg::TRIG_PULSE_CYC
) (
	input  wire logic                    sys_clk,
	input  wire logic                    rst_n,
	input  dpa_pkg::dpa_pins_t           pins,
	output logic                         tdi_o,
	output logic                         tdi_oe,
	output logic                         tdo_o,
	output logic                         tdo_oe,
	output logic                         trig_o,
	output logic                         trig_oe,
	input  wire logic                    trig_event,
	output logic                         instr_en,
	output logic                         mode_valid,
	output logic                         sdbg_en,
	output logic                         sdbg_clk,
	output logic                         sdbg_data_in,
	input  wire logic                    sdbg_data_out,
	input  wire logic                    sdbg_data_oe,
	input  wire logic [dpa_pkg::DBG_W-1:0] dbg_status,
	output logic      [dpa_pkg::DBG_W-1:0] dbg_wr_data,
	output logic                         dbg_wr_stb
);
	import dpa_pkg::*;

	// ----------------------------------------------------------------
	// Pin synchronizers and test clock edge detection
	// ----------------------------------------------------------------
	dpa_pins_t       pins_s;
	logic            tck_s;
	logic            tms_s;
	logic            tdi_s;
	logic            tck_d_q;
	logic            tck_rise;
	logic            tck_fall;

	dpa_sync #(.W(3)) u_sync (
		.sys_clk  (sys_clk),
		.async_in (pins),
		.sync_out (pins_s)
	);

	assign tck_s = pins_s.tck;
	assign tms_s = pins_s.tms;
	assign tdi_s = pins_s.tdi;

	always_ff @(posedge sys_clk) begin
		tck_d_q <= tck_s;
	end

	// Each test clock level lasts at least one system cycle, so no edge is missed
	assign tck_rise = tck_s & ~tck_d_q;
	assign tck_fall = ~tck_s & tck_d_q;

	// ----------------------------------------------------------------
	// Mode selection at the end of reset
	// ----------------------------------------------------------------
	logic [SEL_LOW_MIN-1:0] low_hist_q;
	logic [SEL_LOW_MIN-1:0] low_hist_d;
	logic                   sel_done_q;
	logic                   sel_done_d;
	logic                   instr_en_q;
	logic                   instr_en_d;

	always_comb begin
		low_hist_d = {low_hist_q[SEL_LOW_MIN-2:0], ~tck_s};
		sel_done_d = sel_done_q;
		instr_en_d = instr_en_q;
		if (!rst_n) begin
			sel_done_d = 1'b0;
			instr_en_d = 1'b0;
		end else if (!sel_done_q) begin
			sel_done_d = 1'b1;
			instr_en_d = &low_hist_q;
		end
	end

	always_ff @(posedge sys_clk) begin
		low_hist_q <= low_hist_d;
		sel_done_q <= sel_done_d;
		instr_en_q <= instr_en_d;
	end

	assign instr_en   = instr_en_q;
	assign mode_valid = sel_done_q;

	// ----------------------------------------------------------------
	// Serial debug interface sharing the clock and data-in pins
	// ----------------------------------------------------------------
	assign sdbg_en      = sel_done_q & ~instr_en_q;
	assign sdbg_clk     = tck_s;
	assign sdbg_data_in = tdi_s;
	assign tdi_oe       = sdbg_en & sdbg_data_oe;
	assign tdi_o        = sdbg_en & sdbg_data_oe & sdbg_data_out;

	// ----------------------------------------------------------------
	// Test access port controller
	// ----------------------------------------------------------------
	dpa_tap_state_t tap_state;

	dpa_tap u_tap (
		.sys_clk    (sys_clk),
		.rst_n      (rst_n),
		.step       (tck_rise & instr_en_q),
		.tms        (tms_s),
		.hold_reset (~instr_en_q),
		.state      (tap_state)
	);

	// ----------------------------------------------------------------
	// Instruction and data shift paths
	// ----------------------------------------------------------------
	logic [IR_W-1:0]   ir_q;
	logic [IR_W-1:0]   ir_d;
	logic [IR_W-1:0]   ir_sr_q;
	logic [IR_W-1:0]   ir_sr_d;
	logic [DR_MAX-1:0] dr_sr_q;
	logic [DR_MAX-1:0] dr_sr_d;
	logic [4:0]        dr_msb;
	logic              tdo_q;
	logic              tdo_d;
	logic              tdo_oe_q;
	logic              tdo_oe_d;
	logic [DBG_W-1:0]  wr_data_q;
	logic [DBG_W-1:0]  wr_data_d;
	logic              wr_stb_q;
	logic              wr_stb_d;

	// Length of the selected data register; unknown codes fall back to bypass
	always_comb begin
		if (ir_q == IR_IDCODE) begin
			dr_msb = MSB_IDCODE;
		end else if (ir_q == IR_DBG) begin
			dr_msb = MSB_DBG;
		end else begin
			dr_msb = MSB_BYPASS;
		end
	end

	always_comb begin
		ir_d      = ir_q;
		ir_sr_d   = ir_sr_q;
		dr_sr_d   = dr_sr_q;
		tdo_d     = tdo_q;
		tdo_oe_d  = tdo_oe_q;
		wr_data_d = wr_data_q;
		wr_stb_d  = 1'b0;
		if (!instr_en_q || tap_state == TLR) begin
			ir_d = IR_IDCODE;
		end
		if (instr_en_q && tck_rise) begin
			case (tap_state)
				CAP_IR: begin
					ir_sr_d = IR_CAPTURE;
				end
				SH_IR: begin
					ir_sr_d = {tdi_s, ir_sr_q[IR_W-1:1]};
				end
				CAP_DR: begin
					if (ir_q == IR_IDCODE) begin
						dr_sr_d = IDCODE_VAL;
					end else if (ir_q == IR_DBG) begin
						dr_sr_d = {{(DR_MAX-DBG_W){1'b0}}, dbg_status};
					end else begin
						dr_sr_d = '0;
					end
				end
				SH_DR: begin
					dr_sr_d         = dr_sr_q >> 1;
					dr_sr_d[dr_msb] = tdi_s;
				end
				default: begin
				end
			endcase
		end
		if (instr_en_q && tck_fall) begin
			case (tap_state)
				SH_IR: begin
					tdo_d    = ir_sr_q[0];
					tdo_oe_d = 1'b1;
				end
				SH_DR: begin
					tdo_d    = dr_sr_q[0];
					tdo_oe_d = 1'b1;
				end
				UPD_IR: begin
					ir_d     = ir_sr_q;
					tdo_oe_d = 1'b0;
				end
				UPD_DR: begin
					tdo_oe_d = 1'b0;
					if (ir_q == IR_DBG) begin
						wr_data_d = dr_sr_q[DBG_W-1:0];
						wr_stb_d  = 1'b1;
					end
				end
				default: begin
					tdo_oe_d = 1'b0;
				end
			endcase
		end
		if (!instr_en_q) begin
			tdo_oe_d = 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			ir_q      <= IR_IDCODE;
			ir_sr_q   <= '0;
			dr_sr_q   <= '0;
			tdo_q     <= 1'b0;
			tdo_oe_q  <= 1'b0;
			wr_data_q <= '0;
			wr_stb_q  <= 1'b0;
		end else begin
			ir_q      <= ir_d;
			ir_sr_q   <= ir_sr_d;
			dr_sr_q   <= dr_sr_d;
			tdo_q     <= tdo_d;
			tdo_oe_q  <= tdo_oe_d;
			wr_data_q <= wr_data_d;
			wr_stb_q  <= wr_stb_d;
		end
	end

	assign tdo_o       = tdo_q;
	assign tdo_oe      = tdo_oe_q;
	assign dbg_wr_data = wr_data_q;
	assign dbg_wr_stb  = wr_stb_q;

	// ----------------------------------------------------------------
	// Trigger output pulse
	// ----------------------------------------------------------------
	logic [7:0] trig_cnt_q;
	logic [7:0] trig_cnt_d;
	logic       trig_q;
	logic       trig_d;

	always_comb begin
		trig_cnt_d = trig_cnt_q;
		if (instr_en_q && trig_event) begin
			trig_cnt_d = 8'(TRIG_CYC);
		end else if (trig_cnt_q != 8'h00) begin
			trig_cnt_d = trig_cnt_q - 8'h01;
		end
		trig_d = (trig_cnt_d != 8'h00);
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			trig_cnt_q <= 8'h00;
			trig_q     <= 1'b0;
		end else begin
			trig_cnt_q <= trig_cnt_d;
			trig_q     <= trig_d;
		end
	end

	assign trig_o  = trig_q;
	assign trig_oe = trig_q;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	property p_sel_low;
		!sel_done_q && (&low_hist_q) |=> (instr_en_q && sel_done_q) [*2];
	endproperty
	a_sel_low: assert property (p_sel_low)
		else $error("instrumentation not enabled after low test clock at reset");

	property p_sel_high;
		!sel_done_q && !(&low_hist_q) |=> !instr_en_q && sdbg_en;
	endproperty
	a_sel_high: assert property (p_sel_high)
		else $error("instrumentation enabled after high test clock at reset");

	property p_sdbg_pins;
		sdbg_en |-> sdbg_clk == tck_s && sdbg_data_in == tdi_s && tap_state == TLR;
	endproperty
	a_sdbg_pins: assert property (p_sdbg_pins)
		else $error("serial debug interface not carried on the shared pins");

	property p_tdi_dir;
		tdi_oe |-> sel_done_q && !instr_en_q;
	endproperty
	a_tdi_dir: assert property (p_tdi_dir)
		else $error("data-in pin driven while instrumentation enabled");

	property p_tms_step;
		instr_en_q && tck_rise && tap_state == RTI && tms_s |=> tap_state == SEL_DR;
	endproperty
	a_tms_step: assert property (p_tms_step)
		else $error("mode select not applied on test clock rise");

	property p_shift_in;
		instr_en_q && tck_rise && tap_state == SH_IR |=> ir_sr_q[IR_W-1] == $past(tdi_s);
	endproperty
	a_shift_in: assert property (p_shift_in)
		else $error("data-in not captured on test clock rise");

	property p_tdo_fall;
		$changed(tdo_q) |-> $past(tck_fall);
	endproperty
	a_tdo_fall: assert property (p_tdo_fall)
		else $error("data-out changed away from a test clock fall");

	property p_trig_pulse;
		instr_en_q && trig_event |=> (trig_oe && trig_o) [*2];
	endproperty
	a_trig_pulse: assert property (p_trig_pulse)
		else $error("trigger pulse missing or short");

	property p_trig_idle;
		!instr_en_q |-> !trig_oe && !trig_o;
	endproperty
	a_trig_idle: assert property (p_trig_idle)
		else $error("trigger pin driven while instrumentation is off");

	property p_tap_reset;
		instr_en_q && tck_rise && tap_state == SEL_IR && tms_s |=> tap_state == TLR ##1 ir_q == IR_IDCODE;
	endproperty
	a_tap_reset: assert property (p_tap_reset)
		else $error("controller failed to reach reset with idcode selected");

	property p_edge;
		tck_rise |-> tck_s && !$past(tck_s);
	endproperty
	a_edge: assert property (p_edge)
		else $error("test clock rise detected without a synchronized low to high");

endmodule : dpa_top

// file: dv/dpa_probe.sv
// Debugger probe model for the four-wire test port and the shared data pin
module dpa_probe (
	input  wire logic          sys_clk,
	input  wire logic          tdo_o,
	input  wire logic          dev_tdi_o,
	input  wire logic          dev_tdi_oe,
	output dpa_pkg::dpa_pins_t pins
);
	timeunit 1ns;
	timeprecision 1ps;
	import dpa_pkg::*;

	logic tck_q = 1'b0;
	logic tms_q = 1'b1;
	logic tdi_q = 1'b1;
	logic drv_q = 1'b1;

	// Released data line floats to its pull-up level
	assign pins = '{tck: tck_q, tms: tms_q, tdi: dev_tdi_oe ? dev_tdi_o : (drv_q ? tdi_q : 1'b1)};

	task automatic set_lines(input logic ck, input logic d, input logic drv);
		@(negedge sys_clk);
		tck_q = ck;
		tdi_q = d;
		drv_q = drv;
	endtask : set_lines

	// One test clock: four system cycles low, four high
	task automatic clk_bit(input logic m, input logic d, output logic q);
		@(negedge sys_clk);
		tms_q = m;
		tdi_q = d;
		repeat (3) @(negedge sys_clk);
		q     = tdo_o;
		tck_q = 1'b1;
		repeat (4) @(negedge sys_clk);
		tck_q = 1'b0;
	endtask : clk_bit
endmodule : dpa_probe

// file: dv/tb_top.sv
// Self-checking bench for the debug port activation block
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import dpa_pkg::*;

	// ----
	// Clock, design and probe
	// ----
	logic             sys_clk       = 1'b0;
	logic             rst_n         = 1'b0;
	logic             trig_event    = 1'b0;
	logic             sdbg_data_out = 1'b1;
	logic             sdbg_data_oe  = 1'b0;
	logic [DBG_W-1:0] dbg_status    = 8'h3c;
	logic [DBG_W-1:0] dbg_wr_data;
	dpa_pins_t        pins;
	logic             tdi_o, tdi_oe, tdo_o, tdo_oe, trig_o, trig_oe;
	logic             instr_en, mode_valid, sdbg_en, sdbg_clk, sdbg_data_in, dbg_wr_stb;
	int               fails = 0, tests_run = 0, cycles = 0, stb_cnt = 0;

	always #20 sys_clk = ~sys_clk;

	dpa_top #(.TRIG_CYC(2)) uut (.sys_clk, .rst_n, .pins, .tdi_o, .tdi_oe, .tdo_o, .tdo_oe, .trig_o, .trig_oe,
		.trig_event, .instr_en, .mode_valid, .sdbg_en, .sdbg_clk, .sdbg_data_in, .sdbg_data_out,
		.sdbg_data_oe, .dbg_status, .dbg_wr_data, .dbg_wr_stb);

	dpa_probe probe (.sys_clk, .tdo_o, .dev_tdi_o(tdi_o), .dev_tdi_oe(tdi_oe), .pins);

	// ----
	// Checks, monitors and closing
	// ----
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic end_sim();
		$display("counts: %0d compared, %0d mismatched", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : end_sim

	// Run needs about 1150 cycles
	always @(posedge sys_clk) begin
		cycles++;
		if (dbg_wr_stb === 1'b1) begin
			stb_cnt++;
		end
		if (cycles == 20000) begin
			fails++;
			end_sim();
		end
	end

	// Data-out may move only while the test clock is low
	always @(tdo_o) begin
		if (rst_n === 1'b1 && instr_en === 1'b1) begin
			check(pins.tck, 1'b0);
		end
	end

	// ----
	// Helpers and scenarios
	// ----
	task automatic do_reset(input logic ck);
		@(negedge sys_clk);
		rst_n = 1'b0;
		probe.set_lines(ck, 1'b1, 1'b1);
		repeat (5) @(negedge sys_clk);
		rst_n = 1'b1;
		repeat (3) @(negedge sys_clk);
	endtask : do_reset

	task automatic tap_reset();
		logic q;
		repeat (5) probe.clk_bit(1'b1, 1'b1, q);
		probe.clk_bit(1'b0, 1'b1, q);
	endtask : tap_reset

	// From idle: select, capture, shift n bits LSB first, update, back to idle
	task automatic scan(input logic ir, input logic [31:0] din, input int n, output logic [31:0] dout);
		logic q;
		dout = '0;
		probe.clk_bit(1'b1, 1'b1, q);
		if (ir) begin
			probe.clk_bit(1'b1, 1'b1, q);
		end
		probe.clk_bit(1'b0, 1'b1, q);
		probe.clk_bit(1'b0, 1'b1, q);
		for (int i = 0; i < n; i++) begin
			probe.clk_bit(i == n - 1, din[i], q);
			dout[i] = q;
			check(tdo_oe, 1'b1);
		end
		probe.clk_bit(1'b1, 1'b1, q);
		probe.clk_bit(1'b0, 1'b1, q);
		repeat (4) @(negedge sys_clk);
		check(tdo_oe, 1'b0);
	endtask : scan

	task automatic t_select_low();
		do_reset(1'b0);
		check({instr_en, mode_valid, sdbg_en}, 3'b110);
		sdbg_data_out = 1'b0;
		sdbg_data_oe  = 1'b1;
		@(negedge sys_clk);
		check({tdi_oe, pins.tdi}, 2'b01);
		sdbg_data_oe = 1'b0;
		$display("done select_low");
	endtask : t_select_low

	task automatic t_tap_chain();
		logic [31:0] d;
		tap_reset();
		scan(1'b0, 32'h0, 32, d);
		check(d, IDCODE_VAL);
		scan(1'b1, {28'h0, IR_BYPASS}, 4, d);
		check(d[3:0], IR_CAPTURE);
		scan(1'b0, 32'hb, 4, d);
		check(d[3:0], 4'h6);
		scan(1'b1, {28'h0, IR_DBG}, 4, d);
		scan(1'b0, 32'ha5, DBG_W, d);
		check(d[7:0], dbg_status);
		check(dbg_wr_data, 8'ha5);
		check(stb_cnt, 1);
		// Leaving through the instruction select with mode select high falls back to idcode
		tap_reset();
		scan(1'b0, 32'h0, 32, d);
		check(d, IDCODE_VAL);
		$display("done tap_chain");
	endtask : t_tap_chain

	task automatic t_trigger(input logic en);
		trig_event = 1'b1;
		@(negedge sys_clk);
		trig_event = 1'b0;
		for (int i = 0; i < 3; i++) begin
			check({trig_o, trig_oe}, (en && i < 2) ? 2'b11 : 2'b00);
			@(negedge sys_clk);
		end
		$display("done trigger");
	endtask : t_trigger

	task automatic t_select_high();
		logic q;
		do_reset(1'b1);
		check({instr_en, mode_valid, sdbg_en}, 3'b011);
		probe.set_lines(1'b0, 1'b0, 1'b1);
		repeat (3) @(negedge sys_clk);
		check({sdbg_clk, sdbg_data_in}, 2'b00);
		probe.set_lines(1'b1, 1'b0, 1'b0);
		sdbg_data_out = 1'b0;
		sdbg_data_oe  = 1'b1;
		repeat (3) @(negedge sys_clk);
		check({tdi_oe, tdi_o, pins.tdi, sdbg_clk, sdbg_data_in}, 5'b10010);
		sdbg_data_oe = 1'b0;
		repeat (3) @(negedge sys_clk);
		check({tdi_oe, sdbg_data_in}, 2'b01);
		probe.set_lines(1'b0, 1'b1, 1'b1);
		// Mode select 1,0,1,0,0 would reach the data shift state if the controller ran
		for (int i = 3; i >= 0; i--) begin
			probe.clk_bit(i[0], 1'b0, q);
		end
		probe.clk_bit(1'b0, 1'b0, q);
		repeat (4) @(negedge sys_clk);
		check(tdo_oe, 1'b0);
		t_trigger(1'b0);
		$display("done select_high");
	endtask : t_select_high

	initial begin
		t_select_low();
		t_tap_chain();
		t_trigger(1'b1);
		t_select_high();
		t_select_low();
		end_sim();
	end
endmodule : tb_top
